/* File: verilog/event_entry_regs.svh */
// Register offsets, field positions and reset values of the event entry builder
`ifndef EVENT_ENTRY_REGS_SVH
`define EVENT_ENTRY_REGS_SVH

`define EE_REG_CTRL 8'h00
`define EE_REG_STATUS 8'h04
`define EE_REG_EVSEL 8'h08
`define EE_REG_EVCFG 8'h0c
`define EE_REG_EVHIGH 8'h10
`define EE_REG_EVLOW 8'h14
`define EE_REG_EVINIT 8'h18
`define EE_REG_EVLIMIT 8'h1c

`define EE_CTRL_RESET 32'h0000_0000
`define EE_CTRL_HDR 0
`define EE_CTRL_FMT_LO 2
`define EE_CTRL_FMT_HI 3
`define EE_CTRL_ABS 6

`define EE_CFG_MODE_LO 0
`define EE_CFG_MODE_HI 2
`define EE_CFG_PRIO_LO 3
`define EE_CFG_PRIO_HI 5
`define EE_CFG_INITCAP 6
`define EE_CFG_INITVAL 7

`define EE_STAT_INREC 0
`define EE_STAT_BUSY 1

`define EE_FMT_SHORT 2'h0
`define EE_UPPER_ZERO 16'h0000
`define EE_ENTRY_RSVD 3'h0
`define EE_CHAN_RSVD 19'h00000
`define EE_ENTRIES_PER_PKT 12'h001
`define EE_WORDS_PLAIN 3'h4
`define EE_WORDS_HDR 3'h6

`endif

/* File: verilog/event_entry_pkg.sv */
// Types shared by the event entry builder modules
`default_nettype none
package event_entry_pkg;

    typedef enum logic [2:0] {
        TRIG_OFF = 3'h0,
        TRIG_DISC_BOTH = 3'h1,
        TRIG_DISC_ON = 3'h2,
        TRIG_DISC_OFF = 3'h3,
        TRIG_LIM_BOTH = 3'h4,
        TRIG_LIM_HIGH = 3'h5,
        TRIG_LIM_LOW = 3'h6,
        TRIG_CHANGE = 3'h7
    } trig_mode_t;

    typedef enum logic [2:0] {
        PRIO_NONE = 3'h0,
        PRIO_ALWAYS = 3'h1,
        PRIO_REC_ALL_GAP_LIM = 3'h2,
        PRIO_REC_ONLY = 3'h3,
        PRIO_LIM_BOTH = 3'h4,
        PRIO_REC_LIM = 3'h5
    } prio_t;

    typedef struct packed {
        trig_mode_t mode;
        prio_t prio;
        logic initCapture;
        logic initValid;
        logic [31:0] high;
        logic [31:0] low;
        logic [31:0] initValue;
        logic [15:0] limit;
    } evt_cfg_t;

    typedef struct packed {
        logic [11:0] evtNum;
        logic [31:0] value;
        logic [47:0] rtc;
        logic itemOk;
        logic [63:0] itemTag;
        logic [63:0] secHdr;
        logic [63:0] absTime;
    } meas_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic occurrence_phase_flag;
        logic [15:0] count;
        logic [11:0] number;
    } entry_word_t;

    typedef struct packed {
        logic optional_absolute_time_header;
        logic [18:0] rsvd;
        logic [11:0] entry_count_field;
    } channel_word_t;

endpackage
`default_nettype wire

/* File: verilog/trigger_detect.sv */
// Trigger condition check for one measurement against its event setup
`timescale 1ns/1ps
`default_nettype none
module trigger_detect (
    // Event setup
    input wire event_entry_pkg::evt_cfg_t cfg,
    // Sample and remembered previous sample
    input wire logic [31:0] value,
    input wire logic [31:0] prevValue,
    input wire logic prevOk,
    // Result
    output logic fire
);
    wire logic discNew = |(value & cfg.high);
    wire logic discOld = |(prevValue & cfg.high);
    wire logic hiNew = value >= cfg.high;
    wire logic hiOld = prevValue >= cfg.high;
    wire logic loNew = value <= cfg.low;
    wire logic loOld = prevValue <= cfg.low;

    // First sample of a period fires only when initial capture is set
    wire logic onEdge = prevOk ? (discNew & ~discOld)
                               : (cfg.initCapture & discNew);
    wire logic offEdge = prevOk ? (~discNew & discOld)
                                : (cfg.initCapture & ~discNew);
    wire logic hiEdge = prevOk ? (hiNew & ~hiOld)
                               : (cfg.initCapture & hiNew);
    wire logic loEdge = prevOk ? (loNew & ~loOld)
                               : (cfg.initCapture & loNew);

    // Initial value is only a reference, never an event itself
    wire logic [31:0] chgBase = prevOk ? prevValue : cfg.initValue;
    wire logic chgFire = (prevOk | cfg.initValid) & (value != chgBase);

    always_comb begin
        case (cfg.mode)
            event_entry_pkg::TRIG_DISC_BOTH: fire = onEdge | offEdge;
            event_entry_pkg::TRIG_DISC_ON: fire = onEdge;
            event_entry_pkg::TRIG_DISC_OFF: fire = offEdge;
            event_entry_pkg::TRIG_LIM_BOTH: fire = hiEdge | loEdge;
            event_entry_pkg::TRIG_LIM_HIGH: fire = hiEdge;
            event_entry_pkg::TRIG_LIM_LOW: fire = loEdge;
            event_entry_pkg::TRIG_CHANGE: fire = chgFire;
            default: fire = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/occurrence_table.sv */
// Per-event occurrence counters and limit tallies, cleared per capture period
`timescale 1ns/1ps
`default_nettype none
module occurrence_table #(
    parameter int DEPTH = 4096,
    parameter int IDXW = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic [IDXW-1:0] idx,
    input wire logic bump,
    // Looked-up values for idx
    output logic [15:0] count,
    output logic [15:0] tally
);
    logic [15:0] count_q [DEPTH];
    logic [15:0] tally_q [DEPTH];
    logic [DEPTH-1:0] seen_q;

    // Stale entries are masked by seen_q, so one cycle clears them all
    assign count = seen_q[idx] ? count_q[idx] : 16'h0000;
    assign tally = seen_q[idx] ? tally_q[idx] : 16'h0000;
    wire logic [15:0] tallyNext = (tally == 16'hffff) ? tally
                                                      : tally + 16'h0001;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= '0;
        end else if (clear) begin
            seen_q <= '0;
        end else if (bump) begin
            seen_q[idx] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (bump && !clear) begin
            count_q[idx] <= count + 16'h0001;
            tally_q[idx] <= tallyNext;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/recording_event_entry_builder.sv */
// Recording event entry builder: triggers, counters and packet body words
//
// Operation
// - Optionally fire at once if the transition preceded capture.
// - Change mode may start from a set value that itself raises nothing.
// - Change mode limit counts apply to events actually produced.
// - Threshold fires high at or above high, low at or below low.
// - Relative tag carries 48-bit counter, upper 16 of second word zero.
// - Relative tag from trigger packet counter or its item tag if present.
// - Flag bit 6 selects absolute time; bits 2 and 3 give format.
// - Absolute tag from trigger secondary header or absolute item tag.
// - Optional absolute header holds event time, unused upper bits zero.
// - Body order: channel word, then tag, optional header, entry word.
// - Entry bits 31 to 29 are written as zero.
// - Entry bit 28 is one inside a recording, zero between recordings.
// - Entry bits 27 to 12 carry per-event count, first is zero.
// - Counts restart each capture period, increment and wrap after 0xffff.
// - Entry bits 11 to 0 carry the event number of the trigger measurement.
// - Capture period runs from previous stop, or first record, to stop.
// - Priority picks always, limited or never, inside and between recordings.
// - Trigger mode per event: discrete, threshold or value change.
// - Channel word bit 31 flags headers, bits 11 to 0 count entries.
`timescale 1ns/1ps
`default_nettype none
`include "event_entry_regs.svh"
module recording_event_entry_builder #(
    parameter int NUM_EVENTS = 4096
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Recorder commands, one-cycle pulses
    input wire logic recordCmd,
    input wire logic stopCmd,
    // Trigger measurement stream
    input wire event_entry_pkg::meas_t measIn,
    input wire logic measValid,
    output logic measReady,
    // Packet body word stream
    output logic [31:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic outFirst,
    output logic outLast
);
    localparam int IDXW = (NUM_EVENTS > 1) ? $clog2(NUM_EVENTS) : 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } state_t;

    ////////////////////////////////////////////////////////////////////////
    // Register file and event setup table

    logic [31:0] ctrl_q;
    logic [11:0] sel_q;
    logic [31:0] rdata_q;
    event_entry_pkg::evt_cfg_t cfg_q [NUM_EVENTS];
    state_t state_q;
    state_t state_d;
    logic inRec_q;
    logic hadStop_q;

    wire logic [IDXW-1:0] selIdx = sel_q[IDXW-1:0];
    wire logic selOk = {1'b0, sel_q} < 13'(NUM_EVENTS);
    wire event_entry_pkg::evt_cfg_t selCfg = cfg_q[selIdx];
    wire logic wrCtrl = regWr && (regAddr == `EE_REG_CTRL);
    wire logic wrSel = regWr && (regAddr == `EE_REG_EVSEL);
    wire logic wrCfg = regWr && selOk && (regAddr == `EE_REG_EVCFG);
    wire logic wrHigh = regWr && selOk && (regAddr == `EE_REG_EVHIGH);
    wire logic wrLow = regWr && selOk && (regAddr == `EE_REG_EVLOW);
    wire logic wrInit = regWr && selOk && (regAddr == `EE_REG_EVINIT);
    wire logic wrLimit = regWr && selOk && (regAddr == `EE_REG_EVLIMIT);

    wire logic hdrEn = ctrl_q[`EE_CTRL_HDR];
    wire logic absEn = ctrl_q[`EE_CTRL_ABS];
    wire logic [1:0] timeFmt = ctrl_q[`EE_CTRL_FMT_HI:`EE_CTRL_FMT_LO];

    wire logic [31:0] cfgWord = {24'h000000, selCfg.initValid,
                                 selCfg.initCapture, selCfg.prio,
                                 selCfg.mode};
    wire logic [31:0] statWord = {30'h00000000, state_q == ST_SEND, inRec_q};

    logic [31:0] rdMux;
    always_comb begin
        case (regAddr)
            `EE_REG_CTRL: rdMux = ctrl_q;
            `EE_REG_STATUS: rdMux = statWord;
            `EE_REG_EVSEL: rdMux = {20'h00000, sel_q};
            `EE_REG_EVCFG: rdMux = selOk ? cfgWord : 32'h0;
            `EE_REG_EVHIGH: rdMux = selOk ? selCfg.high : 32'h0;
            `EE_REG_EVLOW: rdMux = selOk ? selCfg.low : 32'h0;
            `EE_REG_EVINIT: rdMux = selOk ? selCfg.initValue : 32'h0;
            `EE_REG_EVLIMIT: rdMux = selOk ? {16'h0000, selCfg.limit} : 32'h0;
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `EE_CTRL_RESET;
            sel_q <= 12'h000;
            rdata_q <= 32'h0;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= regWdata;
            end
            if (wrSel) begin
                sel_q <= regWdata[11:0];
            end
            rdata_q <= regRd ? rdMux : 32'h0;
        end
    end
    assign regRdata = rdata_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                cfg_q[i] <= '0;
            end
        end else begin
            if (wrCfg) begin
                cfg_q[selIdx].mode <= event_entry_pkg::trig_mode_t'(
                    regWdata[`EE_CFG_MODE_HI:`EE_CFG_MODE_LO]);
                cfg_q[selIdx].prio <= event_entry_pkg::prio_t'(
                    regWdata[`EE_CFG_PRIO_HI:`EE_CFG_PRIO_LO]);
                cfg_q[selIdx].initCapture <= regWdata[`EE_CFG_INITCAP];
                cfg_q[selIdx].initValid <= regWdata[`EE_CFG_INITVAL];
            end
            if (wrHigh) begin
                cfg_q[selIdx].high <= regWdata;
            end
            if (wrLow) begin
                cfg_q[selIdx].low <= regWdata;
            end
            if (wrInit) begin
                cfg_q[selIdx].initValue <= regWdata;
            end
            if (wrLimit) begin
                cfg_q[selIdx].limit <= regWdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture periods

    // A period ends at each stop; the very first record opens one too
    wire logic boundary = stopCmd | (recordCmd & ~hadStop_q);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inRec_q <= 1'b0;
            hadStop_q <= 1'b0;
        end else if (stopCmd) begin
            inRec_q <= 1'b0;
            hadStop_q <= 1'b1;
        end else if (recordCmd) begin
            inRec_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger evaluation and capture decision

    logic [31:0] prevVal_q [NUM_EVENTS];
    logic [NUM_EVENTS-1:0] prevOk_q;
    logic fire;
    logic [15:0] occCount;
    logic [15:0] occTally;
    logic allow;

    // Stalled during a boundary so no sample straddles two periods
    assign measReady = (state_q == ST_IDLE) && !boundary;
    wire logic measTake = measValid && measReady;
    wire logic [IDXW-1:0] evIdx = measIn.evtNum[IDXW-1:0];
    wire logic evOk = {1'b0, measIn.evtNum} < 13'(NUM_EVENTS);
    wire event_entry_pkg::evt_cfg_t evCfg = cfg_q[evIdx];
    // Tally only grows on produced entries, so change mode limits count
    // real value changes and not raw samples
    wire logic underLimit = occTally < evCfg.limit;

    trigger_detect trig (
        .cfg(evCfg),
        .value(measIn.value),
        .prevValue(prevVal_q[evIdx]),
        .prevOk(prevOk_q[evIdx]),
        .fire(fire)
    );

    always_comb begin
        case (evCfg.prio)
            event_entry_pkg::PRIO_ALWAYS: allow = 1'b1;
            event_entry_pkg::PRIO_REC_ALL_GAP_LIM:
                allow = inRec_q | underLimit;
            event_entry_pkg::PRIO_REC_ONLY: allow = inRec_q;
            event_entry_pkg::PRIO_LIM_BOTH: allow = underLimit;
            event_entry_pkg::PRIO_REC_LIM: allow = inRec_q & underLimit;
            default: allow = 1'b0;
        endcase
    end

    wire logic emit = measTake && evOk && fire && allow;

    occurrence_table #(
        .DEPTH(NUM_EVENTS),
        .IDXW(IDXW)
    ) occ (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(boundary),
        .idx(evIdx),
        .bump(emit),
        .count(occCount),
        .tally(occTally)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevOk_q <= '0;
        end else if (boundary) begin
            prevOk_q <= '0;
        end else if (measTake && evOk) begin
            prevOk_q[evIdx] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (measTake && evOk) begin
            prevVal_q[evIdx] <= measIn.value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word assembly

    // The short time format only fills 48 bits; longer ones use all 64
    function automatic logic [63:0] fillTime(input logic [63:0] t,
                                             input logic [1:0] fmt);
        fillTime = (fmt == `EE_FMT_SHORT) ?
                   {`EE_UPPER_ZERO, t[47:0]} : t;
    endfunction

    wire logic [63:0] relTag = measIn.itemOk ?
        {`EE_UPPER_ZERO, measIn.itemTag[47:0]} :
        {`EE_UPPER_ZERO, measIn.rtc};
    wire logic [63:0] absTag = fillTime(measIn.itemOk ? measIn.itemTag
                                        : measIn.secHdr, timeFmt);
    wire logic [63:0] timeTag = absEn ? absTag : relTag;
    wire logic [63:0] absHdr = fillTime(measIn.absTime, timeFmt);

    event_entry_pkg::channel_word_t chanWord;
    event_entry_pkg::entry_word_t entryWord;
    always_comb begin
        chanWord.optional_absolute_time_header = hdrEn;
        chanWord.rsvd = `EE_CHAN_RSVD;
        chanWord.entry_count_field = `EE_ENTRIES_PER_PKT;
        entryWord.rsvd = `EE_ENTRY_RSVD;
        entryWord.occurrence_phase_flag = inRec_q;
        entryWord.count = occCount;
        entryWord.number = measIn.evtNum;
    end

    logic [31:0] words_d [6];
    always_comb begin
        words_d[0] = chanWord;
        words_d[1] = timeTag[31:0];
        words_d[2] = timeTag[63:32];
        words_d[3] = hdrEn ? absHdr[31:0] : entryWord;
        words_d[4] = hdrEn ? absHdr[63:32] : 32'h0;
        words_d[5] = hdrEn ? entryWord : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output sequencing

    logic [31:0] words_q [6];
    logic [2:0] remain_q;
    logic first_q;
    wire logic outTake = outValid && outReady;

    always_comb begin
        case (state_q)
            ST_IDLE: state_d = emit ? ST_SEND : ST_IDLE;
            ST_SEND: state_d = (outTake && remain_q == 3'h1) ? ST_IDLE
                                                               : ST_SEND;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            remain_q <= 3'h0;
            first_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (emit) begin
                remain_q <= hdrEn ? `EE_WORDS_HDR : `EE_WORDS_PLAIN;
                first_q <= 1'b1;
            end else if (outTake) begin
                remain_q <= remain_q - 3'h1;
                first_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 6; i++) begin
                words_q[i] <= 32'h0;
            end
        end else if (emit) begin
            words_q <= words_d;
        end else if (outTake) begin
            for (int i = 0; i < 5; i++) begin
                words_q[i] <= words_q[i+1];
            end
            words_q[5] <= 32'h0;
        end
    end

    assign outData = words_q[0];
    assign outValid = (state_q == ST_SEND);
    assign outFirst = outValid && first_q;
    assign outLast = outValid && (remain_q == 3'h1);
endmodule
`default_nettype wire

/* File: dv/entry_builder_sva.sv */
// Port property checker for the event entry builder
`timescale 1ns/1ps
`default_nettype none
module entry_builder_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched ports
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic stopCmd,
    input wire logic measValid,
    input wire logic measReady,
    input wire logic [31:0] outData,
    input wire logic outValid,
    input wire logic outReady,
    input wire logic outFirst,
    input wire logic outLast
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data not zero outside read slot");
    out_hold_a: assert property (outValid && !outReady |=>
        outValid && $stable(outData) && $stable(outLast))
        else $error("word changed before taken");
    chan_word_a: assert property (outValid && outFirst |->
        outData[30:0] == 31'h1)
        else $error("channel word wrong");
    entry_rsvd_a: assert property (outValid && outLast |->
        outData[31:29] == 3'h0)
        else $error("entry reserved bits set");
    first_word_a: assert property ($rose(outValid) |->
        outFirst && $past(measValid && measReady))
        else $error("body did not start with channel word");
    pkt_end_a: assert property (outValid && outReady && outFirst |->
        ##[3:300] (outValid && outLast))
        else $error("entry word missing");
    last_done_a: assert property (outValid && outReady && outLast |=>
        !outValid)
        else $error("words after entry word");
    stop_block_a: assert property (stopCmd |-> !measReady)
        else $error("sample taken at period boundary");
    busy_block_a: assert property (outValid |-> !measReady)
        else $error("sample taken while body pending");
endmodule
`default_nettype wire

/* File: dv/stream_sink.sv */
// Packet body consumer with optional back-pressure
`timescale 1ns/1ps
`default_nettype none
module stream_sink (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Stall control
    input wire logic slow,
    // Body word stream
    input wire logic [31:0] outData,
    input wire logic outValid,
    output logic outReady
);
    logic [31:0] got[$];
    // Toggling ready makes each word after the first wait a cycle, which exercises holding
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            outReady <= 1'b1;
        end else begin
            outReady <= slow ? !outReady : 1'b1;
        end
    end
    always @(posedge mclk) begin
        if (rst_n && outValid && outReady) begin
            got.push_back(outData);
        end
    end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the recording event entry builder
`timescale 1ns/1ps
`default_nettype none
`include "event_entry_regs.svh"
module testbench;
    typedef struct packed {
        logic [11:0] n;
        logic [31:0] v;
        logic f;
        logic [15:0] c;
    } row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic recordCmd = 1'b0;
    logic stopCmd = 1'b0;
    event_entry_pkg::meas_t measIn = '0;
    logic measValid = 1'b0;
    logic measReady;
    logic [31:0] outData;
    logic outValid;
    logic outReady;
    logic outFirst;
    logic outLast;
    logic slow = 1'b0;
    logic ph = 1'b0;
    logic hdr = 1'b0;
    logic io = 1'b0;
    logic fs = 1'b0;
    int nErrors = 0;
    int totalChecks = 0;
    row_t rows[26] = '{
        '{12'h0, 32'h0, 1'b0, 16'h0}, '{12'h0, 32'h1, 1'b1, 16'h0},
        '{12'h0, 32'h0, 1'b0, 16'h0}, '{12'h0, 32'h1, 1'b1, 16'h1},
        '{12'h1, 32'h32, 1'b0, 16'h0}, '{12'h1, 32'h64, 1'b1, 16'h0},
        '{12'h1, 32'h63, 1'b0, 16'h0}, '{12'h2, 32'h32, 1'b0, 16'h0},
        '{12'h2, 32'ha, 1'b1, 16'h0}, '{12'h3, 32'h5, 1'b0, 16'h0},
        '{12'h3, 32'h6, 1'b1, 16'h0}, '{12'h3, 32'h6, 1'b0, 16'h0},
        '{12'h3, 32'h5, 1'b1, 16'h1}, '{12'h4, 32'h0, 1'b0, 16'h0},
        '{12'h4, 32'h1, 1'b1, 16'h0}, '{12'h4, 32'h0, 1'b1, 16'h1},
        '{12'h5, 32'h1, 1'b0, 16'h0}, '{12'h5, 32'h0, 1'b1, 16'h0},
        '{12'h6, 32'h32, 1'b0, 16'h0}, '{12'h6, 32'h64, 1'b1, 16'h0},
        '{12'h6, 32'h32, 1'b0, 16'h0}, '{12'h6, 32'ha, 1'b1, 16'h1},
        '{12'h7, 32'h3, 1'b0, 16'h0}, '{12'h7, 32'h4, 1'b1, 16'h0},
        '{12'h7, 32'h5, 1'b0, 16'h0}, '{12'h7, 32'h5, 1'b0, 16'h0}};

    always #2 mclk = ~mclk;

    recording_event_entry_builder #(.NUM_EVENTS(8))
        i_recording_event_entry_builder (
        .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .recordCmd(recordCmd), .stopCmd(stopCmd), .measIn(measIn),
        .measValid(measValid), .measReady(measReady), .outData(outData),
        .outValid(outValid), .outReady(outReady), .outFirst(outFirst),
        .outLast(outLast));
    stream_sink i_stream_sink (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .outData(outData), .outValid(outValid), .outReady(outReady));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, e);
        totalChecks++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            nErrors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        chk(nm, regRdata, e);
    endtask
    // Config byte: init valid, init capture, priority, mode
    task automatic cfg(input logic [11:0] n, input logic [7:0] c,
        input logic [31:0] hi, lo, ini, input logic [15:0] lim);
        wr(`EE_REG_EVSEL, {20'h0, n});
        wr(`EE_REG_EVCFG, {24'h0, c});
        wr(`EE_REG_EVHIGH, hi);
        wr(`EE_REG_EVLOW, lo);
        wr(`EE_REG_EVINIT, ini);
        wr(`EE_REG_EVLIMIT, {16'h0, lim});
    endtask
    task automatic pulse(input logic r);
        @(posedge mclk);
        recordCmd <= r;
        stopCmd <= !r;
        @(posedge mclk);
        recordCmd <= 1'b0;
        stopCmd <= 1'b0;
    endtask
    task automatic ev(input logic [11:0] n, input logic [31:0] v,
        input logic f, input logic [15:0] c);
        logic [63:0] tag;
        logic [31:0] exp[$];
        int i;
        if (hdr) tag = io ? {32'hcafe_d00d, v} : {32'h7777_7777, v};
        else tag = {16'h0, io ? 16'hd00d : 16'hbeef, v};
        // Short absolute format keeps only 48 bits of the time
        if (hdr && fs) tag[63:48] = 16'h0;
        @(posedge mclk);
        measIn <= '{evtNum: n, value: v, rtc: {16'hbeef, v}, itemOk: io,
            itemTag: {32'hcafe_d00d, v}, secHdr: {32'h7777_7777, v},
            absTime: {32'habc_0abc, v}};
        measValid <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 50 && measReady !== 1'b1; i++) @(posedge mclk);
        measValid <= 1'b0;
        if (i == 50) begin
            chk("take", 32'h1, 32'h0);
            wrap_up();
        end
        if (f) exp = '{{hdr, 19'h0, 12'h1}, tag[31:0], tag[63:32]};
        if (f && hdr) exp = {exp, v, fs ? 32'habc : 32'habc_0abc};
        if (f) exp.push_back({3'h0, ph, c, n});
        for (i = 0; i < 60 && i_stream_sink.got.size() < exp.size(); i++)
            @(posedge mclk);
        if (i == 60) begin
            chk("wait", 32'h1, 32'h0);
            wrap_up();
        end
        repeat (3) @(posedge mclk);
        chk("words", 32'(i_stream_sink.got.size()), 32'(exp.size()));
        foreach (exp[k])
            if (k < i_stream_sink.got.size())
                chk("word", i_stream_sink.got[k], exp[k]);
        i_stream_sink.got.delete();
    endtask
    task automatic wrap_up();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk("ready", {31'h0, measReady}, 32'h1);
        chk("valid", {31'h0, outValid}, 32'h0);
        rd(`EE_REG_CTRL, `EE_CTRL_RESET, "ctrl");
        rd(`EE_REG_EVCFG, 32'h0, "cfg reset");
        rd(8'h20, 32'h0, "unmapped");
        cfg(12'h0, 8'h0a, 32'h1, 32'h0, 32'h0, 16'h0);
        cfg(12'h1, 8'h5d, 32'h64, 32'h0, 32'h0, 16'h0);
        cfg(12'h2, 8'h56, 32'h0, 32'ha, 32'h0, 16'h0);
        cfg(12'h3, 8'h8f, 32'h0, 32'h0, 32'h5, 16'h0);
        cfg(12'h4, 8'h09, 32'h1, 32'h0, 32'h0, 16'h0);
        cfg(12'h5, 8'h4b, 32'h1, 32'h0, 32'h0, 16'h0);
        cfg(12'h6, 8'h6c, 32'h64, 32'ha, 32'h0, 16'h2);
        cfg(12'h7, 8'h27, 32'h0, 32'h0, 32'h0, 16'h1);
        rd(`EE_REG_EVCFG, 32'h27, "cfg readback");
        wr(`EE_REG_EVSEL, 32'h8);
        rd(`EE_REG_EVCFG, 32'h0, "cfg range");
        pulse(1'b1);
        ph = 1'b1;
        foreach (rows[k]) ev(rows[k].n, rows[k].v, rows[k].f, rows[k].c);
        pulse(1'b0);
        ph = 1'b0;
        ev(12'h1, 32'h64, 1'b0, 16'h0);
        ev(12'h2, 32'h5, 1'b0, 16'h0);
        ev(12'h6, 32'h64, 1'b0, 16'h0);
        ev(12'h5, 32'h0, 1'b1, 16'h0);
        ev(12'h0, 32'h0, 1'b0, 16'h0);
        ev(12'h0, 32'h1, 1'b1, 16'h0);
        wr(`EE_REG_CTRL, 32'h45);
        hdr = 1'b1;
        slow <= 1'b1;
        ev(12'h4, 32'h1, 1'b0, 16'h0);
        ev(12'h4, 32'h0, 1'b1, 16'h0);
        io = 1'b1;
        ev(12'h4, 32'h1, 1'b1, 16'h1);
        wr(`EE_REG_CTRL, 32'h41);
        fs = 1'b1;
        ev(12'h4, 32'h0, 1'b1, 16'h2);
        wr(`EE_REG_CTRL, 32'h0);
        hdr = 1'b0;
        ev(12'h4, 32'h1, 1'b1, 16'h3);
        io = 1'b0;
        slow <= 1'b0;
        pulse(1'b1);
        ph = 1'b1;
        ev(12'h4, 32'h0, 1'b1, 16'h4);
        rd(`EE_REG_STATUS, 32'h1, "status");
        wrap_up();
    end
endmodule
bind recording_event_entry_builder entry_builder_sva i_entry_builder_sva (
    .mclk(mclk), .rst_n(rst_n), .regRd(regRd), .regRdata(regRdata),
    .stopCmd(stopCmd), .measValid(measValid), .measReady(measReady),
    .outData(outData), .outValid(outValid), .outReady(outReady),
    .outFirst(outFirst), .outLast(outLast));
`default_nettype wire
